//--- hdl/ahp_pkg.sv
// Package with constants and types for the converter host port control.
package ahp_pkg;
  localparam int DATA_W = 10;
  localparam int CTRL_W = 10;
  localparam int CHAN_LO_POS = 0;
  localparam int DUAL_SAMPLE_POS = 6;
  localparam int HALF_SCALE_POS = 7;
  localparam int POWER_DOWN_POS = 8;
  localparam int STATUS_POL_POS = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
  localparam logic [DATA_W-1:0] RESULT_RESET = 10'h000;
  localparam int CONV_CYCLES = 14;
  localparam int ACQ_CYCLES = 5;
  localparam logic [4:0] CONV_LAST = 5'(CONV_CYCLES - 1);
  localparam logic [4:0] ACQ_LAST = 5'(ACQ_CYCLES - 1);
  localparam logic [4:0] CNT_ZERO = 5'h00;

  typedef enum logic [2:0] {
    AHP_IDLE = 3'b000,
    AHP_ACQ = 3'b001,
    AHP_CONV1 = 3'b010,
    AHP_CONV2 = 3'b011,
    AHP_PDOWN = 3'b100
  } ahp_state_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } ahp_strobe_t;

  typedef struct packed {
    logic [DATA_W-1:0] dout;
    logic oe;
  } ahp_dport_t;
endpackage

//--- hdl/ahp_sync.sv
// Two-stage synchroniser with falling and rising edge pulses.
`timescale 1ns/1ns
module ahp_sync
  import ahp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Asynchronous level
  input wire logic din,
  // Synchronised level and edges
  output logic level,
  output logic fall,
  output logic rise
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign fall = prev_ff & ~sync_ff;
  assign rise = ~prev_ff & sync_ff;
endmodule // ahp_sync

//--- hdl/ahp_ctrl.sv
// Converter host port control: strobes, control word, sequencing and power-down.
`timescale 1ns/1ns
// How it works
// - Strobes keep being decoded while powered down.
// - Results stay held through power-down when no conversion ran.
// - Leaving power-down starts a single or dual sequence automatically.
// - That automatic sequence overwrites results with its invalid data.
// - Writing power-down bit zero leaves power-down.
// - Other control bits survive power-down; exit write reloads them all.
// - Status output is high during power-down.
// - Chip select high keeps the data port released.
// - Write strobe with chip select loads control word and starts sequence.
// - Read strobe with chip select drives selected result onto data port.
// - Single mode reads always return the first result.
// - Dual mode reads alternate first, second, first, second.
// - Read during conversion aborts it and returns invalid data.
// - Write during conversion aborts, forces status high, restarts sequence.
// - Each conversion takes fourteen conversion clock cycles.
// - Acquisition lasts about five conversion clock cycles after write.
// - Last conversion updates status; results go to first or second register.
// - Polarity zero: low while converting; one: low after completion.
// - Writing power-down bit one aborts conversion, status high.
module ahp_ctrl
  import ahp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Host strobes, active low
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  // Parallel data port
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // Conversion clock in, sampled
  input wire logic conversion_clock_in,
  // Analog front end result
  input wire logic [DATA_W-1:0] sample_value,
  // Status output, active low busy or done
  output logic busy_int_n,
  // Loose status
  output logic [CTRL_W-1:0] ctrl_word,
  output logic powered_down
);
  ahp_strobe_t strb;
  logic cs_fall_unused;
  logic cs_rise_unused;
  logic rd_fall;
  logic rd_rise_unused;
  logic wr_fall;
  logic wr_rise;
  logic clk_level_unused;
  logic clk_rise;
  logic clk_fall_unused;

  ahp_sync u_cs (.ref_clk(ref_clk), .sys_rst(sys_rst), .din(cs_n), .level(strb.cs_n),
    .fall(cs_fall_unused), .rise(cs_rise_unused));
  ahp_sync u_rd (.ref_clk(ref_clk), .sys_rst(sys_rst), .din(rd_n), .level(strb.rd_n),
    .fall(rd_fall), .rise(rd_rise_unused));
  ahp_sync u_wr (.ref_clk(ref_clk), .sys_rst(sys_rst), .din(wr_n), .level(strb.wr_n),
    .fall(wr_fall), .rise(wr_rise));
  ahp_sync u_ck (.ref_clk(ref_clk), .sys_rst(sys_rst), .din(conversion_clock_in),
    .level(clk_level_unused), .fall(clk_fall_unused), .rise(clk_rise));

  // Data lines pass two flops too, so they align with the write strobe edge.
  logic [DATA_W-1:0] din_meta_ff;
  logic [DATA_W-1:0] din_sync_ff;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      din_meta_ff <= RESULT_RESET;
      din_sync_ff <= RESULT_RESET;
    end else begin
      din_meta_ff <= data_in;
      din_sync_ff <= din_meta_ff;
    end
  end

  // Decoded host cycles, strobes stay live in every state.
  logic wr_start;
  logic wr_load;
  logic rd_start;
  assign wr_start = wr_fall & ~strb.cs_n & strb.rd_n;
  assign wr_load = wr_rise & ~strb.cs_n & strb.rd_n;
  assign rd_start = rd_fall & ~strb.cs_n & strb.wr_n;

  ahp_state_t state_ff, nxt_state;
  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [DATA_W-1:0] res1_ff, nxt_res1;
  logic [DATA_W-1:0] res2_ff, nxt_res2;
  logic [DATA_W-1:0] sar_ff, nxt_sar;
  logic [4:0] cnt_ff, nxt_cnt;
  logic rdptr_ff, nxt_rdptr;
  logic done_ff, nxt_done;
  logic wr_pend_ff, nxt_wr_pend;
  logic corrupt_ff, nxt_corrupt;
  logic [DATA_W-1:0] data_out_ff, nxt_data_out;
  logic data_oe_ff, nxt_data_oe;
  logic busy_ff, nxt_busy;

  logic converting;
  assign converting = (state_ff == AHP_ACQ) || (state_ff == AHP_CONV1) ||
    (state_ff == AHP_CONV2);

  always_comb begin
    nxt_state = state_ff;
    nxt_ctrl = ctrl_ff;
    nxt_res1 = res1_ff;
    nxt_res2 = res2_ff;
    nxt_sar = sar_ff;
    nxt_cnt = cnt_ff;
    nxt_rdptr = rdptr_ff;
    nxt_done = done_ff;
    nxt_wr_pend = wr_pend_ff;
    nxt_corrupt = corrupt_ff;
    if (wr_start) begin
      nxt_wr_pend = 1'b1;
      nxt_done = 1'b0;
      if (state_ff != AHP_PDOWN) begin
        nxt_state = AHP_IDLE;
      end
    end
    if (wr_load && wr_pend_ff) begin
      nxt_wr_pend = 1'b0;
      nxt_ctrl = din_sync_ff;
      nxt_rdptr = 1'b0;
      nxt_cnt = CNT_ZERO;
      nxt_done = 1'b0;
      if (din_sync_ff[POWER_DOWN_POS]) begin
        nxt_state = AHP_PDOWN;
      end else begin
        nxt_corrupt = (state_ff == AHP_PDOWN);
        nxt_state = AHP_ACQ;
      end
    end else if (rd_start) begin
      if (converting) begin
        nxt_state = AHP_IDLE;
        nxt_done = 1'b0;
      end else begin
        nxt_rdptr = ctrl_ff[DUAL_SAMPLE_POS] ? ~rdptr_ff : 1'b0;
      end
    end else if (clk_rise && !wr_pend_ff && !wr_start) begin
      unique case (state_ff)
        AHP_IDLE: begin
        end
        AHP_PDOWN: begin
        end
        AHP_ACQ: begin
          nxt_cnt = cnt_ff + 5'h01;
          if (cnt_ff == ACQ_LAST) begin
            nxt_cnt = CNT_ZERO;
            nxt_state = AHP_CONV1;
          end
        end
        AHP_CONV1, AHP_CONV2: begin
          nxt_cnt = cnt_ff + 5'h01;
          nxt_sar = corrupt_ff ? ~sample_value : sample_value;
          if (cnt_ff == CONV_LAST) begin
            nxt_cnt = CNT_ZERO;
            if (state_ff == AHP_CONV1) begin
              nxt_res1 = nxt_sar;
              if (ctrl_ff[DUAL_SAMPLE_POS]) begin
                nxt_state = AHP_CONV2;
              end else begin
                nxt_state = AHP_IDLE;
                nxt_done = 1'b1;
                nxt_corrupt = 1'b0;
              end
            end else begin
              nxt_res2 = nxt_sar;
              nxt_state = AHP_IDLE;
              nxt_done = 1'b1;
              nxt_corrupt = 1'b0;
            end
          end
        end
        default: nxt_state = AHP_IDLE;
      endcase
    end
  end

  // Data port and status output.
  always_comb begin
    nxt_data_oe = ~strb.cs_n & ~strb.rd_n;
    nxt_data_out = data_out_ff;
    if (rd_start) begin
      if (converting) begin
        nxt_data_out = sar_ff;
      end else begin
        nxt_data_out = rdptr_ff ? res2_ff : res1_ff;
      end
    end
    if (nxt_state == AHP_PDOWN || wr_pend_ff || wr_start) begin
      nxt_busy = 1'b1;
    end else if (ctrl_ff[STATUS_POL_POS]) begin
      nxt_busy = ~nxt_done;
    end else begin
      nxt_busy = ~(nxt_state == AHP_ACQ || nxt_state == AHP_CONV1 ||
        nxt_state == AHP_CONV2);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= AHP_IDLE;
      ctrl_ff <= CTRL_RESET;
      res1_ff <= RESULT_RESET;
      res2_ff <= RESULT_RESET;
      sar_ff <= RESULT_RESET;
      cnt_ff <= CNT_ZERO;
      rdptr_ff <= 1'b0;
      done_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      corrupt_ff <= 1'b0;
      data_out_ff <= RESULT_RESET;
      data_oe_ff <= 1'b0;
      busy_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      ctrl_ff <= nxt_ctrl;
      res1_ff <= nxt_res1;
      res2_ff <= nxt_res2;
      sar_ff <= nxt_sar;
      cnt_ff <= nxt_cnt;
      rdptr_ff <= nxt_rdptr;
      done_ff <= nxt_done;
      wr_pend_ff <= nxt_wr_pend;
      corrupt_ff <= nxt_corrupt;
      data_out_ff <= nxt_data_out;
      data_oe_ff <= nxt_data_oe;
      busy_ff <= nxt_busy;
    end
  end

  // Loose status registers.
  logic [CTRL_W-1:0] ctrl_word_ff;
  logic pd_ff;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_word_ff <= CTRL_RESET;
      pd_ff <= 1'b0;
    end else begin
      ctrl_word_ff <= nxt_ctrl;
      pd_ff <= (nxt_state == AHP_PDOWN);
    end
  end

  assign data_out = data_out_ff;
  assign data_oe = data_oe_ff;
  assign busy_int_n = busy_ff;
  assign ctrl_word = ctrl_word_ff;
  assign powered_down = pd_ff;

  // Checks.
  chk_pdown_status: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_ff == AHP_PDOWN) |=> busy_int_n)
    else $error("status not high in power-down");
  chk_port_release: assert property (@(posedge ref_clk) disable iff (sys_rst)
    strb.cs_n |=> !data_oe)
    else $error("data port driven with chip select high");
  chk_port_drive: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!strb.cs_n && !strb.rd_n) |=> data_oe)
    else $error("data port not driven during read");
  chk_single_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rd_start && !converting && !ctrl_ff[DUAL_SAMPLE_POS]) |=> data_out == $past(res1_ff))
    else $error("single mode read not first result");
  chk_dual_toggle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rd_start && !converting && ctrl_ff[DUAL_SAMPLE_POS] && !wr_load)
    |=> rdptr_ff != $past(rdptr_ff))
    else $error("dual mode pointer did not alternate");
  chk_read_abort: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rd_start && converting && !wr_load) |=> state_ff == AHP_IDLE)
    else $error("read did not abort conversion");
  chk_write_ptr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_load && wr_pend_ff) |=> !rdptr_ff)
    else $error("pointer not reset on write");
  chk_pd_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_load && wr_pend_ff && din_sync_ff[POWER_DOWN_POS]) |=> ##1 powered_down && busy_int_n)
    else $error("power-down entry failed");
  chk_wr_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_start |=> busy_int_n)
    else $error("write fall did not force status high");
  chk_res_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_ff == AHP_PDOWN && $past(state_ff == AHP_PDOWN)) |-> $stable(res1_ff))
    else $error("result changed during power-down");
  cov_dual_done: cover property (@(posedge ref_clk) disable iff (sys_rst)
    state_ff == AHP_CONV2 ##1 state_ff == AHP_IDLE);
  cov_pd_exit: cover property (@(posedge ref_clk) disable iff (sys_rst)
    state_ff == AHP_PDOWN ##1 state_ff == AHP_ACQ);
  cov_read_abort: cover property (@(posedge ref_clk) disable iff (sys_rst)
    rd_start && converting);
endmodule // ahp_ctrl

//--- bench/ahp_host_model.sv
// Bus master model that drives the host strobes and the data port lines.
`timescale 1ns/1ns
module ahp_host_model
  import ahp_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Host strobes and data lines
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [DATA_W-1:0] data_in
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 10'h2aa;
  end
  // Writes one control word with a low pulse on the write strobe.
  task automatic wr_cycle(input logic [CTRL_W-1:0] w);
    @(posedge ref_clk);
    #1;
    cs_n = 1'b0;
    data_in = w;
    wr_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    wr_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    cs_n = 1'b1;
    data_in = ~w;
    repeat (6) @(posedge ref_clk);
  endtask
  // Reads one result with a low pulse on the read strobe.
  task automatic rd_cycle();
    @(posedge ref_clk);
    #1;
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule // ahp_host_model

//--- bench/adc_host_port_powerdown_control_bench.sv
// Self-checking bench for the converter host port control.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module adc_host_port_powerdown_control_bench
  import ahp_pkg::*;
;
  logic ref_clk;
  logic sys_rst;
  logic conv_clk;
  logic [DATA_W-1:0] sample_value;
  logic cs_n, rd_n, wr_n, data_oe, busy_int_n, powered_down, oe_q;
  logic [DATA_W-1:0] data_in, data_out, s, t, exp_v;
  logic [CTRL_W-1:0] ctrl_word;
  logic [DATA_W-1:0] exp_q[$];
  int num_errors = 0;
  int total_checks = 0;
  int seed = 16712;
  int n;
  always #5 ref_clk = ~ref_clk;
  always #20 if (powered_down !== 1'b1) conv_clk = ~conv_clk;
  ahp_host_model host_u (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .data_in(data_in));
  ahp_ctrl dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .conversion_clock_in(conv_clk), .sample_value(sample_value),
    .busy_int_n(busy_int_n), .ctrl_word(ctrl_word), .powered_down(powered_down));
  task automatic stop_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Waits a bounded time for the status output to reach a level.
  task automatic wait_busy(input logic lvl, output int cnt);
    cnt = 0;
    while (busy_int_n !== lvl) begin
      @(posedge ref_clk);
      #1;
      cnt++;
      if (cnt > 600) begin
        num_errors++;
        stop_test();
      end
    end
  endtask
  task automatic rd_exp(input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    host_u.rd_cycle();
  endtask
  // Takes the oldest expected value when the data port starts driving.
  always @(posedge ref_clk) begin
    if (data_oe === 1'b1 && oe_q !== 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        exp_v = exp_q.pop_front();
        `CHK(data_out, exp_v)
      end
    end
    oe_q <= data_oe;
  end
  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    conv_clk = 1'b0;
    sample_value = 10'($random(seed));
    repeat (16) @(posedge ref_clk);
    #1;
    `CHK({data_oe, busy_int_n, powered_down}, 3'b010)
    `CHK(ctrl_word, CTRL_RESET)
    sys_rst = 1'b0;
    s = 10'($random(seed));
    sample_value = s;
    host_u.wr_cycle(10'h003);
    `CHK(ctrl_word, 10'h003)
    wait_busy(1'b0, n);
    wait_busy(1'b1, n);
    `CHK((n >= 66 && n <= 90), 1'b1)
    rd_exp(s);
    rd_exp(s);
    `CHK(data_oe, 1'b0)
    s = 10'($random(seed));
    sample_value = s;
    host_u.wr_cycle(10'h041);
    wait_busy(1'b0, n);
    repeat (100) @(posedge ref_clk);
    #1;
    t = 10'($random(seed));
    sample_value = t;
    wait_busy(1'b1, n);
    rd_exp(s);
    rd_exp(t);
    rd_exp(s);
    host_u.wr_cycle(10'h141);
    `CHK({powered_down, busy_int_n}, 2'b11)
    sample_value = ~s;
    rd_exp(s);
    sample_value = s;
    host_u.wr_cycle(10'h041);
    `CHK({powered_down, ctrl_word}, {1'b0, 10'h041})
    wait_busy(1'b0, n);
    wait_busy(1'b1, n);
    rd_exp(~s);
    rd_exp(~s);
    s = 10'($random(seed));
    sample_value = s;
    host_u.wr_cycle(10'h200);
    wait_busy(1'b0, n);
    `CHK((n >= 60 && n <= 90), 1'b1)
    rd_exp(s);
    host_u.wr_cycle(10'h003);
    wait_busy(1'b0, n);
    repeat (40) @(posedge ref_clk);
    fork
      host_u.wr_cycle(10'h003);
      begin
        repeat (5) @(posedge ref_clk);
        #1;
        `CHK(busy_int_n, 1'b1)
      end
    join
    wait_busy(1'b1, n);
    rd_exp(s);
    host_u.wr_cycle(10'h003);
    repeat (40) @(posedge ref_clk);
    rd_exp(s);
    `CHK(busy_int_n, 1'b1)
    repeat (10) @(posedge ref_clk);
    `CHK(exp_q.size(), 0)
    stop_test();
  end
endmodule // adc_host_port_powerdown_control_bench
